// *** core/acl_top.sv ***
// conversion sequencer, cell limit check and auxiliary redundancy check behind APB
`timescale 1ns/100ps
module acl_top
  import acl_pkg::*;
#(
  parameter int unsigned CYC_PER_US = CYCLES_PER_US
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // register bus
  input  wire acl_apb_req_type apbReq,
  output acl_apb_rsp_type      apbRsp,
  // digital filter results
  input  wire logic [15:0]     cellResIn [CELLS],
  input  wire logic [15:0]     auxResA,
  input  wire logic [15:0]     auxResB,
  // converter steering and status
  output logic [2:0]           auxChanSel,
  output logic                 convActive,
  output logic                 measPhase,
  output logic                 irq
);

  typedef struct packed {
    acl_seq_type                       seq;
    acl_mode_type                      mode;
    logic                              isAux;
    logic                              redund;
    logic                              auxAll;
    logic [2:0]                        auxIdx;
    logic [US_CNT_W-1:0]               usCnt;
    logic [US_CNT_W-1:0]               slotCnt;
    logic [15:0]                       uvTh;
    logic [15:0]                       ovTh;
    logic [CELLS-1:0]                  uvFlag;
    logic [CELLS-1:0]                  ovFlag;
    logic [CELLS-1:0][RES_W-1:0]       cellPend;
    logic [CELLS-1:0][RES_W-1:0]       cellRes;
    logic [AUX_CHANS-1:0][RES_W-1:0]   auxRes;
    logic [IRQ_W-1:0]                  irqStat;
    logic [IRQ_W-1:0]                  irqMask;
    acl_apb_rsp_type                   rsp;
    logic                              irq;
    logic                              active;
    logic                              meas;
  } acl_state_type;

  acl_state_type r;
  acl_state_type n;

  logic                tick;
  logic                startCmd;
  logic [15:0]         redOut;
  logic                redFault;
  logic                cellCommit;
  logic                auxCapture;
  logic                lastSlot;
  logic [US_CNT_W-1:0] measEnd;
  logic [US_CNT_W-1:0] calEnd;
  logic [US_CNT_W-1:0] slotLen;

  // microsecond time base, restarted by each accepted command
  acl_us_tick #(
    .CYC (CYC_PER_US)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clear   (startCmd),
    .tick    (tick)
  );

  // both filter results of the first converter's stream are compared
  acl_redund_check u_red (
    .resA   (auxResA),
    .resB   (auxResB),
    .resOut (redOut),
    .fault  (redFault)
  );

  // phase end times; the redundant flag never enters the timing
  always_comb begin
    if (r.isAux && r.auxAll) begin
      measEnd = US_CNT_W'(AUX_T6M_US[r.mode]);
      calEnd  = US_CNT_W'(AUX_T6C_US[r.mode]);
    end else begin
      measEnd = US_CNT_W'(CELL_T1M_US[r.mode]);
      calEnd  = US_CNT_W'(CELL_T1C_US[r.mode]);
    end
    slotLen  = US_CNT_W'(AUX_T6M_US[r.mode] / AUX_SLOTS);
    lastSlot = !(r.isAux && r.auxAll) || (r.auxIdx == 3'(AUX_CHANS - 1));
  end

  // whole next-state function
  always_comb begin
    logic setup;
    logic access;
    logic [2:0] sel;
    logic slotDone;
    logic [2:0] aIdx;
    setup      = 1'b0;
    access     = 1'b0;
    sel        = '0;
    slotDone   = 1'b0;
    aIdx       = '0;
    n          = r;
    startCmd   = 1'b0;
    cellCommit = 1'b0;
    auxCapture = 1'b0;
    n.rsp.pready  = 1'b0;
    n.rsp.pslverr = 1'b0;
    setup  = apbReq.psel && !apbReq.penable && !r.rsp.pready;
    access = apbReq.psel && apbReq.penable && r.rsp.pready;

    // read data is prepared in the setup cycle so it leaves a flop
    if (setup) begin
      n.rsp.pready = 1'b1;
      n.rsp.prdata = '0;
      if (!apbReq.pwrite) begin
        case (apbReq.paddr)
          REG_CTRL: begin
            n.rsp.prdata[BUSY_BIT] = (r.seq != SEQ_IDLE);
            n.rsp.prdata[CTRL_MODE_LSB +: 3] = r.mode;
          end
          REG_THRESH: begin
            n.rsp.prdata = {r.ovTh, r.uvTh};
          end
          REG_STATB: begin
            n.rsp.prdata[STB_UV_LSB +: CELLS] = r.uvFlag;
            n.rsp.prdata[STB_OV_LSB +: CELLS] = r.ovFlag;
          end
          REG_CELLRES: begin
            n.rsp.prdata = {r.cellRes[1], r.cellRes[0]};
          end
          REG_IRQ_STAT: begin
            n.rsp.prdata[IRQ_W-1:0] = r.irqStat;
          end
          REG_IRQ_MASK: begin
            n.rsp.prdata[IRQ_W-1:0] = r.irqMask;
          end
          default: begin
            if (apbReq.paddr >= REG_AUX0 && apbReq.paddr <= REG_AUX_LAST
                && apbReq.paddr[1:0] == 2'b00) begin
              aIdx = 3'((apbReq.paddr - REG_AUX0) >> 2);
              n.rsp.prdata[RES_W-1:0] = r.auxRes[aIdx];
            end else begin
              n.rsp.pslverr = 1'b1;
            end
          end
        endcase
      end else if (!(apbReq.paddr inside {REG_CTRL, REG_THRESH, REG_IRQ_MASK})) begin
        n.rsp.pslverr = 1'b1;
      end
    end

    // writes take effect at the completing edge only
    if (access && apbReq.pwrite) begin
      case (apbReq.paddr)
        REG_CTRL: begin
          sel = apbReq.pwdata[CTRL_SEL_LSB +: 3];
          // a command while busy, or an auxiliary command with an unknown select and no cell bit, is dropped
          if (r.seq == SEQ_IDLE && (apbReq.pwdata[CTRL_CELL_BIT]
              || (apbReq.pwdata[CTRL_AUX_BIT] && sel <= SEL_MAX))) begin
            startCmd  = 1'b1;
            n.seq     = SEQ_MEAS;
            n.usCnt   = '0;
            n.slotCnt = '0;
            n.mode    = acl_mode_type'(apbReq.pwdata[CTRL_MODE_LSB +: 3]);
            n.isAux   = !apbReq.pwdata[CTRL_CELL_BIT];
            n.redund  = apbReq.pwdata[CTRL_RED_BIT];
            n.auxAll  = (sel == SEL_ALL);
            n.auxIdx  = (sel == SEL_ALL) ? 3'h0 : sel - 3'h1;
          end
        end
        REG_THRESH: begin
          n.uvTh = apbReq.pwdata[THR_UV_LSB +: 16];
          n.ovTh = apbReq.pwdata[THR_OV_LSB +: 16];
        end
        REG_IRQ_MASK: begin
          n.irqMask = apbReq.pwdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // read clears only what was reported, so a later event survives
    if (access && !apbReq.pwrite && apbReq.paddr == REG_IRQ_STAT) begin
      n.irqStat = r.irqStat & ~r.rsp.prdata[IRQ_W-1:0];
    end

    // conversion sequence
    case (r.seq)
      SEQ_IDLE: begin
      end
      SEQ_MEAS: begin
        if (tick) begin
          n.usCnt   = r.usCnt + 1'b1;
          n.slotCnt = r.slotCnt + 1'b1;
          slotDone  = lastSlot ? (n.usCnt == measEnd) : (n.slotCnt == slotLen);
          if (slotDone) begin
            if (r.isAux) begin
              auxCapture = 1'b1;
              // each channel written once its own measurement is over
              n.auxRes[r.auxIdx] = r.redund ? redOut : acl_clamp(auxResA);
              if (r.redund && redFault) begin
                n.irqStat[IRQ_FAULT] = 1'b1;
              end
            end else begin
              for (int i = 0; i < CELLS; i++) begin
                n.cellPend[i] = acl_clamp(cellResIn[i]);
              end
            end
            n.slotCnt = '0;
            if (lastSlot) begin
              n.seq = SEQ_CAL;
            end else begin
              n.auxIdx = r.auxIdx + 3'h1;
            end
          end
        end
      end
      SEQ_CAL: begin
        if (tick) begin
          n.usCnt = r.usCnt + 1'b1;
          if (n.usCnt == calEnd) begin
            n.seq = SEQ_IDLE;
            if (r.isAux) begin
              n.irqStat[IRQ_AUX] = 1'b1;
            end else begin
              cellCommit = 1'b1;
              n.irqStat[IRQ_CELL] = 1'b1;
              // cell results and limit flags land together after calibration
              for (int i = 0; i < CELLS; i++) begin
                n.cellRes[i] = r.cellPend[i];
                n.ovFlag[i]  = r.cellPend[i] > r.ovTh;
                n.uvFlag[i]  = r.cellPend[i] < r.uvTh;
              end
              if (|n.ovFlag || |n.uvFlag) begin
                n.irqStat[IRQ_LIMIT] = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        n.seq = SEQ_IDLE;
      end
    endcase

    // status pins get their own flops so no decode sits between state and pin
    n.active = (n.seq != SEQ_IDLE);
    n.meas   = (n.seq == SEQ_MEAS);
    n.irq = |(n.irqStat & n.irqMask);
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r         <= '0;
      r.uvTh    <= UV_RST;
      r.ovTh    <= OV_RST;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign apbRsp     = r.rsp;
  assign auxChanSel = r.auxIdx;
  assign convActive = r.active;
  assign measPhase  = r.meas;
  assign irq        = r.irq;

  // checks on the design's own behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_ov_flag_set: assert property (cellCommit |=>
    ovFlag_ok(r.ovFlag, $past(r.cellPend), $past(r.ovTh)))
    else $error("overvoltage flag does not match compare");

  a_uv_flag_set: assert property (cellCommit |=>
    (r.uvFlag[0] == ($past(r.cellPend[0]) < $past(r.uvTh))))
    else $error("undervoltage flag does not match compare");

  a_status_read: assert property (
    (apbReq.psel && !apbReq.penable && !r.rsp.pready && !apbReq.pwrite
     && apbReq.paddr == REG_STATB) |=> (r.rsp.prdata[STB_OV_LSB +: CELLS] == $past(r.ovFlag)))
    else $error("status read lost the limit flags");

  a_cal_end_time: assert property (
    ($past(r.seq) == SEQ_CAL && r.seq == SEQ_IDLE) |-> ($past(r.usCnt) + 1'b1 == $past(calEnd)))
    else $error("conversion ended at the wrong time");

  a_aux_sel_honour: assert property (
    (startCmd && n.isAux && !n.auxAll) |=> (r.auxIdx == $past(n.auxIdx)) && r.isAux)
    else $error("selected channel not taken");

  a_aux_seq_order: assert property (
    (auxCapture && !lastSlot) |=> (r.auxIdx == $past(r.auxIdx) + 3'h1) && (r.seq == SEQ_MEAS))
    else $error("auxiliary sequence skipped a channel");

  a_fault_code_form: assert property (
    (auxCapture && r.redund && redFault) |=>
    (r.auxRes[$past(r.auxIdx)][15:4] == FAULT_HI) && (r.auxRes[$past(r.auxIdx)][3:0] != 4'h0))
    else $error("fault code malformed");

  a_result_range: assert property (
    (auxCapture && !(r.redund && redFault)) |=> (r.auxRes[$past(r.auxIdx)] <= RES_MAX))
    else $error("valid result above range");

  a_result_hold: assert property (!auxCapture |=> $stable(r.auxRes))
    else $error("result changed without a finished measurement");

  function automatic logic ovFlag_ok(input logic [CELLS-1:0] f,
                                     input logic [CELLS-1:0][RES_W-1:0] p,
                                     input logic [15:0] th);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < CELLS; i++) begin
      ok = ok && (f[i] == (p[i] > th));
    end
    return ok;
  endfunction

  c_cell_done: cover property (cellCommit);
  c_aux_full: cover property (auxCapture && r.auxAll && lastSlot);
  c_red_fault: cover property (auxCapture && r.redund && redFault);
  c_limit_irq: cover property (cellCommit ##1 r.irqStat[IRQ_LIMIT]);

endmodule

// *** core/acl_pkg.sv ***
// shared constants, types and helpers for the conversion sequencer and limit checker
package acl_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned CYCLES_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // converter modes, fastest first
  typedef enum logic [2:0] {
    MODE_27K, MODE_14K, MODE_7K, MODE_3K, MODE_2K, MODE_1K, MODE_422, MODE_26
  } acl_mode_type;

  // two-cell conversion: end of measurement and of calibration, in us
  localparam int unsigned CELL_T1M_US [8] = '{57, 86, 144, 240, 493, 959, 1890, 29817};
  localparam int unsigned CELL_T1C_US [8] = '{201, 230, 405, 501, 754, 1219, 2150, 33568};
  // full auxiliary sequence: end of last measurement and of last calibration, in us
  localparam int unsigned AUX_T6M_US [8] = '{290, 465, 814, 1512, 2908, 5701, 11287, 178850};
  localparam int unsigned AUX_T6C_US [8] = '{1113, 1288, 2335, 3033, 4430, 7222, 12807, 201317};
  localparam int unsigned AUX_SLOTS = 6;
  localparam int unsigned US_CNT_W  = 18;

  // result format
  localparam int unsigned RES_W      = 16;
  localparam int unsigned CELLS      = 2;
  localparam int unsigned AUX_CHANS  = 6;
  localparam logic [15:0] RES_MAX    = 16'hDFFF;
  localparam logic [11:0] FAULT_HI   = 12'hFF0;

  // channel select codes in the command
  localparam logic [2:0] SEL_ALL = 3'h0;
  localparam logic [2:0] SEL_MAX = 3'h6;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_THRESH   = 8'h04;
  localparam logic [7:0] REG_STATB    = 8'h08;
  localparam logic [7:0] REG_CELLRES  = 8'h0C;
  localparam logic [7:0] REG_AUX0     = 8'h10;
  localparam logic [7:0] REG_AUX_LAST = 8'h24;
  localparam logic [7:0] REG_IRQ_STAT = 8'h28;
  localparam logic [7:0] REG_IRQ_MASK = 8'h2C;

  // field positions
  localparam int unsigned CTRL_CELL_BIT = 0;
  localparam int unsigned CTRL_AUX_BIT  = 1;
  localparam int unsigned CTRL_RED_BIT  = 2;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_SEL_LSB  = 8;
  localparam int unsigned BUSY_BIT      = 31;
  localparam int unsigned THR_UV_LSB    = 0;
  localparam int unsigned THR_OV_LSB    = 16;
  localparam int unsigned STB_UV_LSB    = 0;
  localparam int unsigned STB_OV_LSB    = 2;

  // interrupt events
  localparam int unsigned IRQ_W     = 4;
  localparam int unsigned IRQ_CELL  = 0;
  localparam int unsigned IRQ_AUX   = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_LIMIT = 3;

  // reset values
  localparam logic [15:0] UV_RST = 16'h0000;
  localparam logic [15:0] OV_RST = 16'hDFFF;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_MEAS, SEQ_CAL} acl_seq_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } acl_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acl_apb_rsp_type;

  // negative readings already floor at zero; top code values are kept for fault codes
  function automatic logic [15:0] acl_clamp(input logic [15:0] v);
    return (v > RES_MAX) ? RES_MAX : v;
  endfunction

endpackage

// *** core/acl_us_tick.sv ***
// one-cycle enable pulse once per microsecond, restartable
`timescale 1ns/100ps
module acl_us_tick
  import acl_pkg::*;
#(
  parameter int unsigned CYC = CYCLES_PER_US
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // control and pulse
  input  wire logic clear,
  output logic      tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } acl_tick_state_type;

  acl_tick_state_type r;
  acl_tick_state_type n;

  // restart aligns the first microsecond with the command
  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (clear) begin
      n.cnt = '0;
    end else if (r.cnt == 16'(CYC - 1)) begin
      n.cnt  = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

// *** core/acl_redund_check.sv ***
// compares the two filter results of one measurement and forms the stored value
`timescale 1ns/100ps
module acl_redund_check
  import acl_pkg::*;
(
  // results from both filters
  input  wire logic [15:0] resA,
  input  wire logic [15:0] resB,
  // stored value and fault flag
  output logic [15:0]      resOut,
  output logic             fault
);

  logic [3:0] nibMis;

  // one mismatch bit per nibble, bit 3 for the top nibble
  for (genvar g = 0; g < 4; g++) begin : g_nib
    assign nibMis[g] = |(resA[4*g+3:4*g] ^ resB[4*g+3:4*g]);
  end

  // low nibble is never zero on a fault, since a fault needs a mismatch
  assign fault  = |nibMis;
  assign resOut = fault ? {FAULT_HI, nibMis} : acl_clamp(resA);

endmodule

// *** tb/acl_filter_model.sv ***
// stand-in for the converter filters that feed results to the sequencer
`timescale 1ns/100ps
module acl_filter_model
  import acl_pkg::*;
(
  // test settings
  input  wire logic [15:0] cellA,
  input  wire logic [15:0] cellB,
  input  wire logic [15:0] auxBase,
  input  wire logic [2:0]  errChan,
  input  wire logic [15:0] errMask,
  // converter steering
  input  wire logic [2:0]  auxChanSel,
  // filter results
  output logic [15:0]      cellRes [CELLS],
  output logic [15:0]      auxResA,
  output logic [15:0]      auxResB
);
  // first filter result follows the channel in progress
  assign auxResA = auxBase + 16'(auxChanSel);
  // both filters see one bit stream; one chosen channel gets a corrupted copy
  assign auxResB = (auxChanSel == errChan) ? (auxResA ^ errMask) : auxResA;
  // cell results come straight from the bench
  assign cellRes[0] = cellA;
  assign cellRes[1] = cellB;
endmodule

// *** tb/tb.sv ***
// self-checking bench for the conversion sequencer and limit checker
`timescale 1ns/100ps
module tb
  import acl_pkg::*;
;
  localparam int unsigned CYC = 2;
  typedef struct {
    logic [2:0] mode; logic [15:0] c1, c2, uv, ov; logic [3:0] flags; logic [31:0] res;
  } acl_row_type;
  // one row per converter mode: cell inputs, thresholds, flags and packed results
  acl_row_type rows [8] = '{
    '{3'h0, 16'h03E8, 16'h07D0, 16'h05DC, 16'h0BB8, 4'h1, 32'h07D0_03E8},
    '{3'h1, 16'h0BB9, 16'h0BB8, 16'h05DC, 16'h0BB8, 4'h4, 32'h0BB8_0BB9},
    '{3'h2, 16'h05DB, 16'hF000, 16'h05DC, 16'h0BB8, 4'h9, 32'hDFFF_05DB},
    '{3'h3, 16'h05DC, 16'h05DC, 16'h05DC, 16'h05DC, 4'h0, 32'h05DC_05DC},
    '{3'h4, 16'h0000, 16'hDFFF, 16'h0001, 16'hDFFE, 4'h9, 32'hDFFF_0000},
    '{3'h5, 16'h0800, 16'h0100, 16'h0200, 16'h0700, 4'h6, 32'h0100_0800},
    '{3'h6, 16'h0400, 16'h0400, 16'h0100, 16'h0900, 4'h0, 32'h0400_0400},
    '{3'h7, 16'h1000, 16'h0050, 16'h0100, 16'h0F00, 4'h6, 32'h0050_1000}};
  logic            ref_clk, rst_n, convActive, measPhase, irq, err;
  acl_apb_req_type apbReq;
  acl_apb_rsp_type apbRsp;
  logic [15:0]     cellRes [CELLS];
  logic [15:0]     auxResA, auxResB, cellA, cellB, auxBase, errMask, expv;
  logic [2:0]      auxChanSel, errChan;
  logic [31:0]     rd;
  logic [5:0]      seen;
  int              n_mismatch, n_compared, tM, tC;

  acl_top #(.CYC_PER_US(CYC)) acl_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .cellResIn(cellRes), .auxResA(auxResA), .auxResB(auxResB), .auxChanSel(auxChanSel),
    .convActive(convActive), .measPhase(measPhase), .irq(irq));
  acl_filter_model acl_filter_model_i (
    .cellA(cellA), .cellB(cellB), .auxBase(auxBase), .errChan(errChan), .errMask(errMask),
    .auxChanSel(auxChanSel), .cellRes(cellRes), .auxResA(auxResA), .auxResB(auxResB));

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // cycle counts may trail the tick count by the registering stages only
  task automatic chk_time(input string name, input int exp, input int got);
    n_compared++;
    if (got < exp || got > exp + 3) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  // one APB transfer; the answer is awaited, never assumed
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    if (n != 1) chk("pready wait", 32'h1, 32'(n));
    apbReq <= '0;
  endtask
  task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    chk(name, exp, rd);
  endtask
  task automatic cmd(input logic cl, ax, rdn, input logic [2:0] mode, sel);
    apb(1'b1, REG_CTRL, {21'h0, sel, 1'b0, mode, 1'b0, rdn, ax, cl});
  endtask
  // counts cycles from command to end of measurement and of calibration
  task automatic run_conv();
    tM = 0;
    tC = 0;
    seen = '0;
    for (int n = 1; n < 80000; n++) begin
      @(posedge ref_clk);
      if (tM == 0 && measPhase !== 1'b1) tM = n;
      if (auxChanSel < 3'h6) seen[auxChanSel] = 1'b1;
      if (convActive !== 1'b1) begin
        tC = n;
        break;
      end
    end
  endtask

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog: the slowest mode alone takes about 67k cycles
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    {cellA, cellB, auxBase, errMask, errChan} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("convActive", 32'h0, convActive);
    chk("irq", 32'h0, irq);
    rdchk("thresh", REG_THRESH, {OV_RST, UV_RST});
    rdchk("statb", REG_STATB, 32'h0);
    apb(1'b1, 8'h30, 32'h1);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, REG_IRQ_MASK, 32'hF);
    // cell conversions in every mode
    foreach (rows[i]) begin
      apb(1'b1, REG_THRESH, {rows[i].ov, rows[i].uv});
      cellA <= rows[i].c1;
      cellB <= rows[i].c2;
      cmd(1'b1, 1'b0, 1'b0, rows[i].mode, 3'h0);
      run_conv();
      chk_time("meas end", CELL_T1M_US[rows[i].mode] * CYC, tM);
      chk_time("cal end", CELL_T1C_US[rows[i].mode] * CYC, tC);
      chk("irq raised", 32'h1, irq);
      rdchk("statb", REG_STATB, {28'h0, rows[i].flags});
      rdchk("cellres", REG_CELLRES, rows[i].res);
      rdchk("irqstat", REG_IRQ_STAT, {28'h0, |rows[i].flags, 3'b001});
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 32'h0, irq);
    end
    // full auxiliary sequence, plain then redundant; a cell command while busy is ignored
    auxBase <= 16'hDFFC;
    errChan <= 3'h3;
    errMask <= 16'h0F01;
    for (int r = 0; r < 2; r++) begin
      cmd(1'b0, 1'b1, r[0], 3'h0, SEL_ALL);
      apb(1'b1, REG_CTRL, 32'h1);
      run_conv();
      chk("channels", 32'h3F, seen);
      chk_time("aux meas end", AUX_T6M_US[0] * CYC, tM + 3);
      chk_time("aux end", AUX_T6C_US[0] * CYC, tC + 3);
      for (int k = 0; k < 6; k++) begin
        expv = (k > 3) ? 16'hDFFF : 16'hDFFC + 16'(k);
        if (r == 1 && k == 3) expv = {FAULT_HI, 4'h5};
        rdchk("aux result", REG_AUX0 + 8'(4 * k), {16'h0, expv});
      end
      rdchk("irqstat", REG_IRQ_STAT, (r == 1) ? 32'h6 : 32'h2);
    end
    // reset in mid-conversion; held four edges so no check sees a half-reset history
    apb(1'b1, REG_THRESH, 32'h1234_0567);
    cmd(1'b1, 1'b0, 1'b0, 3'h2, 3'h0);
    rdchk("busy", REG_CTRL, 32'h8000_0020);
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("reset active", 32'h0, convActive);
    chk("reset meas", 32'h0, measPhase);
    chk("reset irq", 32'h0, irq);
    rdchk("reset thresh", REG_THRESH, {OV_RST, UV_RST});
    rdchk("reset cellres", REG_CELLRES, 32'h0);
    // each single channel in its own mode, interrupt masked; the previous channel keeps its old value
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    for (int s = 1; s <= 6; s++) begin
      auxBase <= 16'(s) << 12;
      cmd(1'b0, 1'b1, 1'b0, 3'(s - 1), 3'(s));
      run_conv();
      chk_time("single end", CELL_T1C_US[s - 1] * CYC, tC);
      rdchk("single", REG_AUX0 + 8'(4 * (s - 1)), {16'h0, 16'(s) << 12 | 16'(s - 1)});
      if (s > 1) begin
        rdchk("kept", REG_AUX0 + 8'(4 * (s - 2)), {16'h0, 16'(s - 1) << 12 | 16'(s - 2)});
      end
      chk("irq masked", 32'h0, irq);
    end
    apb(1'b1, REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("irq unmasked", 32'h1, irq);
    rdchk("irqstat", REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk("irq off", 32'h0, irq);
    wrap_up();
  end
endmodule
